// *** hdl/sar_adc_serial_conversion_ctrl.sv ***
// conversion sequencing and serial readout of a 12-bit sar converter
// Operation
// [RULE1] serial output changes only after rising shift-clock edges
// [RULE2] convert-start fall puts track/hold into hold and starts conversion
// [RULE3] host keeps convert-start high beforehand to prepare a conversion
// [RULE4] track/hold returns to tracking on the 14th rising edge
// [RULE5] after power-up the track/hold tracks at once
// [RULE6] first conversion after power-up calibrates; result flagged invalid
// [RULE7] power-down exit needs no new calibration conversion
// [RULE8] convert-start fall drives the serial output low out of high-z
// [RULE9] each resolved bit goes out immediately, stepped by the shift clock
// [RULE10] msb appears after the 4th rising edge, held until the 5th
// [RULE11] frame is three zeros then twelve bits msb first; sixteen edges
// [RULE12] convert-start rise between edges 14 and 16 keeps output driven; in a frame begun powered down the rise wakes the part and releases it
// [RULE13] low after 16th fall: release at next start rise or clock rise
// [RULE14] result is the 12-bit code of the held differential input
// [RULE15] rise between edges 3 and 14 enters partial power-down
// [RULE16] repeating that sequence from partial enters full power-down
// [RULE17] exit power-down: low for at least 14 clocks before raising
// [RULE18] unipolar codes straight binary, bipolar codes two's complement
// [RULE19] before first conversion output is high-z and counter idle
// [RULE20] rising shift-clock edges are counted from each start fall
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_serial_conversion_ctrl #(
  parameter logic BIPOLAR = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic convert_start_n,
  input wire logic shift_clock,
  input wire logic comparator_high,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic track_hold_tracking,
  output logic [11:0] dac_trial_code,
  output logic converter_powered,
  output logic reference_powered,
  output sar_adc_pkg::result_word_t result_data,
  output logic result_valid,
  input wire logic result_ready
);
  // ==========================================================
  // input synchronisers
  logic [2:0] cs_sync_r, cs_sync_nxt, sc_sync_r, sc_sync_nxt;
  logic cs_lvl_r, cs_lvl_nxt, sc_lvl_r, sc_lvl_nxt;
  logic cs_fall, cs_rise, sc_rise, sc_fall;
  always_comb begin
    cs_sync_nxt = {cs_sync_r[1:0], convert_start_n};
    sc_sync_nxt = {sc_sync_r[1:0], shift_clock};
    cs_lvl_nxt = cs_lvl_r;
    sc_lvl_nxt = sc_lvl_r;
    // a change counts once stages two and three agree
    if (cs_sync_r[1] == cs_sync_r[2]) begin
      cs_lvl_nxt = cs_sync_r[2];
    end
    if (sc_sync_r[1] == sc_sync_r[2]) begin
      sc_lvl_nxt = sc_sync_r[2];
    end
    cs_fall = cs_lvl_r && !cs_lvl_nxt;
    cs_rise = !cs_lvl_r && cs_lvl_nxt;
    sc_rise = !sc_lvl_r && sc_lvl_nxt;
    sc_fall = sc_lvl_r && !sc_lvl_nxt;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_r <= 3'b111;
      sc_sync_r <= `SYNC_ZERO;
      cs_lvl_r <= 1'b1;
      sc_lvl_r <= 1'b0;
    end else begin
      cs_sync_r <= cs_sync_nxt;
      sc_sync_r <= sc_sync_nxt;
      cs_lvl_r <= cs_lvl_nxt;
      sc_lvl_r <= sc_lvl_nxt;
    end
  end
  // ==========================================================
  // conversion sequencer
  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v == `EDGE_MAX) ? v : v + `EDGE_ONE;
  endfunction : sat_inc
  logic [4:0] edge_r, edge_nxt, low_r, low_nxt;
  logic busy_r, busy_nxt, past16_r, past16_nxt, early_r, early_nxt;
  logic track_r, track_nxt, oe_r, oe_nxt, dout_r, dout_nxt;
  logic calib_done_r, calib_done_nxt, calib_cur_r, calib_cur_nxt;
  logic push_r, push_nxt;
  logic [11:0] sar_r, sar_nxt, trial_r, trial_nxt;
  logic [3:0] bit_r, bit_nxt;
  sar_adc_pkg::pwr_mode_t pwr_r, pwr_nxt;
  sar_adc_pkg::result_word_t word_r, word_nxt;
  logic buf_ready;
  logic [11:0] dac_r, dac_nxt;
  logic conv_pwr_r, conv_pwr_nxt, ref_pwr_r, ref_pwr_nxt;
  always_comb begin
    edge_nxt = edge_r;
    busy_nxt = busy_r;
    past16_nxt = past16_r;
    early_nxt = early_r;
    track_nxt = track_r;
    oe_nxt = oe_r;
    dout_nxt = dout_r;
    calib_done_nxt = calib_done_r;
    calib_cur_nxt = calib_cur_r;
    push_nxt = push_r && !buf_ready;
    sar_nxt = sar_r;
    trial_nxt = trial_r;
    bit_nxt = bit_r;
    pwr_nxt = pwr_r;
    word_nxt = word_r;
    low_nxt = cs_lvl_r ? `EDGE_ZERO : low_r;
    if (!cs_lvl_r && sc_rise) begin
      low_nxt = sat_inc(low_r); // RULE17
    end
    if (cs_fall) begin
      // hold and start; output leaves high-z driven low
      track_nxt = 1'b0; // RULE2
      oe_nxt = 1'b1; // RULE8
      dout_nxt = 1'b0; // RULE8
      busy_nxt = 1'b1; // RULE20
      edge_nxt = `EDGE_ZERO; // RULE20
      past16_nxt = 1'b0;
      early_nxt = 1'b0;
      sar_nxt = `RESULT_ZERO;
      trial_nxt = `TRIAL_MSB;
      bit_nxt = `RESULT_MSB;
      calib_cur_nxt = !calib_done_r; // RULE6
      low_nxt = `EDGE_ZERO;
      if (pwr_r != sar_adc_pkg::PWR_ACTIVE) begin
        early_nxt = 1'b1; // RULE17
      end
    end else if (busy_r && sc_rise) begin
      edge_nxt = sat_inc(edge_r); // RULE20
      if (past16_r) begin
        oe_nxt = 1'b0; // RULE13
        busy_nxt = 1'b0;
      end else if (sat_inc(edge_r) >= `EDGE_MSB &&
                   sat_inc(edge_r) < `EDGE_LAST) begin
        // resolve one bit and present it at once
        if (comparator_high) begin
          sar_nxt = sar_r | trial_r; // RULE14 RULE9
        end
        dout_nxt = comparator_high; // RULE9 RULE10 RULE1
        // bipolar: inverted msb turns offset binary into two's complement
        if (BIPOLAR && sat_inc(edge_r) == `EDGE_MSB) begin
          dout_nxt = !comparator_high; // RULE18
        end
        trial_nxt = trial_r >> 1;
        bit_nxt = bit_r - 4'h1;
        if (sat_inc(edge_r) == `EDGE_TRACK) begin
          track_nxt = 1'b1; // RULE4
        end
      end else begin
        dout_nxt = 1'b0; // RULE11 RULE1
      end
      if (sat_inc(edge_r) == `EDGE_TRACK) begin
        track_nxt = 1'b1; // RULE4
      end
      // the word waits for the lsb, which only the 15th edge resolves
      if (sat_inc(edge_r) == `EDGE_LSB) begin
        word_nxt.code = sar_r | (comparator_high ? trial_r : `RESULT_ZERO);
        if (BIPOLAR) begin
          word_nxt.code[11] = ~word_nxt.code[11]; // RULE18
        end
        word_nxt.calibration = calib_cur_r; // RULE6
        push_nxt = 1'b1;
        calib_done_nxt = 1'b1; // RULE6 RULE7
      end
    end else if (busy_r && sc_fall && edge_r == `EDGE_LAST) begin
      past16_nxt = !cs_lvl_r; // RULE13
      if (cs_lvl_r) begin
        busy_nxt = 1'b0; // RULE12
      end
    end else if (busy_r && cs_rise) begin
      if (past16_r) begin
        oe_nxt = 1'b0; // RULE13
        busy_nxt = 1'b0;
      end else if (edge_r >= `EDGE_PD_LO && edge_r < `EDGE_TRACK) begin
        // early rise: abort and step one level deeper; full stays full
        busy_nxt = 1'b0;
        track_nxt = 1'b1;
        oe_nxt = 1'b0;
        pwr_nxt = (pwr_r == sar_adc_pkg::PWR_ACTIVE) ?
          sar_adc_pkg::PWR_PARTIAL : sar_adc_pkg::PWR_FULL; // RULE15 RULE16
      end
    end
    // only a frame begun while powered down can wake the part
    if (cs_rise && early_r && pwr_r != sar_adc_pkg::PWR_ACTIVE &&
        low_r >= `WAKE_EDGES) begin
      pwr_nxt = sar_adc_pkg::PWR_ACTIVE; // RULE17 RULE7
      busy_nxt = 1'b0;
      oe_nxt = 1'b0;
      track_nxt = 1'b1;
    end
    // decoded ahead of the flops so no output pin glitches on a decode
    dac_nxt = sar_nxt | trial_nxt;
    conv_pwr_nxt = (pwr_nxt == sar_adc_pkg::PWR_ACTIVE);
    ref_pwr_nxt = (pwr_nxt != sar_adc_pkg::PWR_FULL);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      edge_r <= `EDGE_ZERO; // RULE19
      dac_r <= `RESULT_ZERO;
      conv_pwr_r <= 1'b1;
      ref_pwr_r <= 1'b1;
      low_r <= `EDGE_ZERO;
      busy_r <= 1'b0; // RULE19
      past16_r <= 1'b0;
      early_r <= 1'b0;
      track_r <= 1'b1; // RULE5
      oe_r <= 1'b0; // RULE19
      dout_r <= 1'b0;
      calib_done_r <= 1'b0;
      calib_cur_r <= 1'b0;
      push_r <= 1'b0;
      sar_r <= `RESULT_ZERO;
      trial_r <= `RESULT_ZERO;
      bit_r <= `RESULT_MSB;
      pwr_r <= sar_adc_pkg::PWR_ACTIVE;
      word_r <= '0;
    end else begin
      edge_r <= edge_nxt;
      dac_r <= dac_nxt;
      conv_pwr_r <= conv_pwr_nxt;
      ref_pwr_r <= ref_pwr_nxt;
      low_r <= low_nxt;
      busy_r <= busy_nxt;
      past16_r <= past16_nxt;
      early_r <= early_nxt;
      track_r <= track_nxt;
      oe_r <= oe_nxt;
      dout_r <= dout_nxt;
      calib_done_r <= calib_done_nxt;
      calib_cur_r <= calib_cur_nxt;
      push_r <= push_nxt;
      sar_r <= sar_nxt;
      trial_r <= trial_nxt;
      bit_r <= bit_nxt;
      pwr_r <= pwr_nxt;
      word_r <= word_nxt;
    end
  end
  // ==========================================================
  // outputs
  // a stalled receiver holds the word in push_r; a fourth word overwrites
  // word_r, the trade for keeping the serial frame free of back-pressure
  result_buffer u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(word_r),
    .in_valid(push_r),
    .in_ready(buf_ready),
    .out_data(result_data),
    .out_valid(result_valid),
    .out_ready(result_ready)
  );
  assign serial_data_out = dout_r;
  assign serial_data_oe = oe_r;
  assign track_hold_tracking = track_r;
  assign dac_trial_code = dac_r;
  assign converter_powered = conv_pwr_r;
  assign reference_powered = ref_pwr_r;
  // ==========================================================
  // checks
  default clocking chk_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_start;
    cs_fall;
  endsequence
  sequence s_wake;
    cs_rise && early_r && pwr_r != sar_adc_pkg::PWR_ACTIVE &&
    low_r >= `WAKE_EDGES;
  endsequence
  AST_HOLD_ON_START: assert property ( // RULE2
    s_start |=> !track_r) else $error("no hold after start");
  AST_DRIVE_LOW: assert property ( // RULE8
    s_start |=> oe_r && !dout_r) else $error("output not driven low");
  AST_TRACK_14: assert property ( // RULE4
    busy_r && sc_rise && !cs_fall && edge_r == 5'h0_d |=> track_r)
    else $error("no tracking at edge 14");
  AST_DOUT_RISE_ONLY: assert property ( // RULE1
    !sc_rise && !cs_fall |=> $stable(dout_r))
    else $error("output moved off a rising edge");
  AST_MSB_4: assert property ( // RULE10
    busy_r && sc_rise && !cs_fall && !past16_r && edge_r == 5'h0_3
    |=> dout_r == ($past(comparator_high) ^ BIPOLAR))
    else $error("msb wrong");
  AST_ZERO_LEAD: assert property ( // RULE11
    busy_r && sc_rise && !cs_fall && edge_r < 5'h0_3 |=> !dout_r)
    else $error("leading zero missing");
  AST_RELEASE: assert property ( // RULE13
    busy_r && past16_r && (sc_rise || cs_rise) && !cs_fall |=> !oe_r)
    else $error("output not released");
  AST_PARTIAL: assert property ( // RULE15
    busy_r && cs_rise && !past16_r && !early_r && edge_r >= 5'h0_3 &&
    edge_r < 5'h0_e && pwr_r == sar_adc_pkg::PWR_ACTIVE
    |=> pwr_r == sar_adc_pkg::PWR_PARTIAL) else $error("no power-down");
  AST_FULL: assert property ( // RULE16
    busy_r && cs_rise && !sc_rise && !past16_r && edge_r >= 5'h0_3 &&
    edge_r < 5'h0_e && pwr_r == sar_adc_pkg::PWR_PARTIAL
    |=> pwr_r == sar_adc_pkg::PWR_FULL) else $error("no full power-down");
  AST_WAKE: assert property ( // RULE17
    s_wake |=> converter_powered && reference_powered)
    else $error("no wake from power-down");
  AST_CALIB_ONCE: assert property ( // RULE6
    calib_done_r |=> calib_done_r) else $error("calibration lost");
endmodule : sar_adc_serial_conversion_ctrl

// *** inc/sar_adc_consts.svh ***
// timing counts, frame positions and reset values of the conversion control
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH
`define EDGE_CNT_W 5
`define EDGE_ZERO 5'h0_0
`define EDGE_ONE 5'h0_1
`define EDGE_PD_LO 5'h0_3
`define EDGE_MSB 5'h0_4
`define EDGE_TRACK 5'h0_e
`define EDGE_LSB 5'h0_f
`define EDGE_LAST 5'h1_0
`define EDGE_MAX 5'h1_f
`define RESULT_W 12
`define RESULT_ZERO 12'h000
`define RESULT_MSB 4'hb
`define TRIAL_MSB 12'h800
`define SYNC_ZERO 3'h0
`define WAKE_EDGES 5'h0_e
`define FIFO_DEPTH 2
`endif

// *** inc/sar_adc_pkg.sv ***
// types shared by the conversion control
package sar_adc_pkg;
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_PARTIAL,
    PWR_FULL
  } pwr_mode_t;
  typedef struct packed {
    logic [11:0] code;
    logic calibration;
  } result_word_t;
  typedef struct packed {
    logic out;
    logic oe;
  } serial_pin_t;
endpackage : sar_adc_pkg

// *** hdl/result_buffer.sv ***
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module result_buffer (
  input wire logic clock,
  input wire logic rst_n,
  input wire sar_adc_pkg::result_word_t in_data,
  input wire logic in_valid,
  output logic in_ready,
  output sar_adc_pkg::result_word_t out_data,
  output logic out_valid,
  input wire logic out_ready
);
  sar_adc_pkg::result_word_t mem_r [`FIFO_DEPTH];
  sar_adc_pkg::result_word_t mem_nxt [`FIFO_DEPTH];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  logic rdy_nxt, vld_nxt;
  sar_adc_pkg::result_word_t dat_nxt;
  always_comb begin
    push = in_valid && (cnt_r != 2'h2);
    pop = out_valid && out_ready;
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    case ({push, pop})
      2'b10: cnt_nxt = cnt_r + 2'h1;
      2'b01: cnt_nxt = cnt_r - 2'h1;
      default: cnt_nxt = cnt_r;
    endcase
    // flags and head word are registered so the block's pins leave flops
    rdy_nxt = (cnt_nxt != 2'h2);
    vld_nxt = (cnt_nxt != 2'h0);
    dat_nxt = mem_nxt[rp_nxt];
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      in_ready <= rdy_nxt;
      out_valid <= vld_nxt;
      out_data <= dat_nxt;
    end
  end
endmodule : result_buffer

// *** verification/host_serial_master.sv ***
// host serial port model that drives convert start and the shift clock
`timescale 1ns/1ps
module host_serial_master (
  input wire logic clock,
  output logic convert_start_n,
  output logic shift_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  // ==========================================================
  // pins and capture
  // shift clock idles low and runs only inside frames
  logic [15:0] frame_r;
  int half_clocks = 8;
  initial begin
    convert_start_n = 1'b1;
    shift_clock = 1'b0;
    frame_r = 16'h0000;
  end
  task automatic wait_clocks(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clocks
  // ==========================================================
  // frame steps
  // convert start was held high for a full half period beforehand
  task automatic start_fall();
    convert_start_n <= 1'b0;
    frame_r = 16'h0000;
    wait_clocks(half_clocks);
  endtask : start_fall
  // a released output is captured as unknown so it never passes a compare
  task automatic edges(input int n);
    repeat (n) begin
      shift_clock <= 1'b1;
      wait_clocks(half_clocks);
      frame_r = {frame_r[14:0],
        (serial_data_oe === 1'b1) ? serial_data_out : 1'bx};
      shift_clock <= 1'b0;
      wait_clocks(half_clocks);
    end
  endtask : edges
  task automatic start_rise();
    convert_start_n <= 1'b1;
    wait_clocks(half_clocks);
  endtask : start_rise
endmodule : host_serial_master

// *** verification/sar_adc_serial_conversion_ctrl_test.sv ***
// self-checking bench of the sar conversion and readout control
`timescale 1ns/1ps
module sar_adc_serial_conversion_ctrl_test;
  // ==========================================================
  // signals and instances
  logic clock;
  logic rst_n;
  logic convert_start_n;
  logic shift_clock;
  logic comparator_high;
  logic serial_data_out;
  logic serial_data_oe;
  logic track_hold_tracking;
  logic [11:0] dac_trial_code;
  logic [11:0] analog_code;
  logic converter_powered;
  logic reference_powered;
  sar_adc_pkg::result_word_t result_data;
  logic result_valid;
  logic result_ready;
  sar_adc_pkg::result_word_t result_data_bi;
  logic result_valid_bi;
  int bad_count = 0;
  int comparisons = 0;
  // ideal comparator: held input sits half a step above its code
  assign comparator_high = (analog_code >= dac_trial_code);
  sar_adc_serial_conversion_ctrl #(
    .BIPOLAR(1'b0)
  ) dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .convert_start_n(convert_start_n),
    .shift_clock(shift_clock),
    .comparator_high(comparator_high),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .track_hold_tracking(track_hold_tracking),
    .dac_trial_code(dac_trial_code),
    .converter_powered(converter_powered),
    .reference_powered(reference_powered),
    .result_data(result_data),
    .result_valid(result_valid),
    .result_ready(result_ready)
  );
  // bipolar twin: same pins and comparator, so only the coding differs
  sar_adc_serial_conversion_ctrl #(
    .BIPOLAR(1'b1)
  ) dut_bi_u (
    .clock(clock),
    .rst_n(rst_n),
    .convert_start_n(convert_start_n),
    .shift_clock(shift_clock),
    .comparator_high(comparator_high),
    .serial_data_out(),
    .serial_data_oe(),
    .track_hold_tracking(),
    .dac_trial_code(),
    .converter_powered(),
    .reference_powered(),
    .result_data(result_data_bi),
    .result_valid(result_valid_bi),
    .result_ready(result_ready)
  );
  host_serial_master host_u (
    .clock(clock),
    .convert_start_n(convert_start_n),
    .shift_clock(shift_clock),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe)
  );
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk
  task automatic chk_frame(input logic [11:0] v);
    chk(host_u.frame_r === {3'b000, v, 1'b0}, "frame bits");
  endtask : chk_frame
  task automatic pop(input logic [11:0] v, input logic cal);
    int n;
    n = 0;
    while (result_valid !== 1'b1 && n < 60) begin
      @(posedge clock);
      n++;
    end
    chk(result_valid === 1'b1, "no result");
    chk(result_data.code === v, "result code");
    chk(result_data.calibration === cal, "calib flag");
    chk(result_valid_bi === 1'b1 &&
      result_data_bi.code === {~v[11], v[10:0]}, "bipolar");
    result_ready <= 1'b1;
    @(posedge clock);
    result_ready <= 1'b0;
    @(posedge clock);
  endtask : pop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // scenarios
  task automatic t_first();
    chk(serial_data_oe === 1'b0, "driven before start");
    chk(track_hold_tracking === 1'b1, "not tracking");
    analog_code <= 12'h3c5;
    host_u.start_fall();
    chk(serial_data_oe === 1'b1, "not driven");
    chk(serial_data_out === 1'b0, "not low");
    chk(track_hold_tracking === 1'b0, "no hold");
    host_u.edges(16);
    chk_frame(12'h3c5);
    chk(serial_data_oe === 1'b1, "early release");
    host_u.start_rise();
    chk(serial_data_oe === 1'b0, "no release on rise");
    $display("calibration frame done");
  endtask : t_first
  // receiver stalls so both words must sit in the buffer
  task automatic t_stall();
    analog_code <= 12'ha5c;
    host_u.start_fall();
    host_u.edges(13);
    chk(track_hold_tracking === 1'b0, "tracks early");
    host_u.edges(1);
    chk(track_hold_tracking === 1'b1, "no tracking");
    host_u.edges(2);
    chk_frame(12'ha5c);
    host_u.edges(1);
    chk(serial_data_oe === 1'b0, "no release on clock");
    host_u.start_rise();
    pop(12'h3c5, 1'b1);
    pop(12'ha5c, 1'b0);
    $display("stall frame done");
  endtask : t_stall
  task automatic t_back();
    analog_code <= 12'hfff;
    host_u.start_fall();
    host_u.edges(15);
    host_u.start_rise();
    host_u.edges(1);
    chk(serial_data_oe === 1'b1, "released in run");
    chk_frame(12'hfff);
    analog_code <= 12'h001;
    host_u.start_fall();
    host_u.edges(16);
    chk_frame(12'h001);
    host_u.start_rise();
    pop(12'hfff, 1'b0);
    pop(12'h001, 1'b0);
    $display("back to back done");
  endtask : t_back
  task automatic t_power();
    host_u.start_fall();
    host_u.edges(5);
    host_u.start_rise();
    chk((converter_powered ^ reference_powered) === 1'b1, "partial");
    host_u.start_fall();
    host_u.edges(5);
    host_u.start_rise();
    chk({converter_powered, reference_powered} === 2'b00, "full");
    host_u.start_fall();
    host_u.edges(16);
    host_u.start_rise();
    chk({converter_powered, reference_powered} === 2'b11, "wake");
    // discard whatever the wake frame left behind
    result_ready <= 1'b1;
    repeat (10) @(posedge clock);
    result_ready <= 1'b0;
    analog_code <= 12'h7ff;
    host_u.start_fall();
    host_u.edges(16);
    chk_frame(12'h7ff);
    host_u.start_rise();
    pop(12'h7ff, 1'b0);
    $display("power-down done");
  endtask : t_power
  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    analog_code = 12'h000;
    result_ready = 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_first();
    t_stall();
    t_back();
    t_power();
    close_out();
  end
  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    close_out();
  end
endmodule : sar_adc_serial_conversion_ctrl_test
